// *** rtl/quad_count_pkg.sv ***
// Purpose: constants and carriers for the four-channel quadrature counter
// Assumes: 125 MHz clock, 8-byte register window addressed by a 3-bit offset
// Notes: busy time and edge-rate limit are derived from the clock rate
package quad_count_pkg;
   localparam int          NUM_CH           = 4;
   localparam int          CLOCK_KHZ        = 125000;
   localparam logic [2:0]  OFS_COUNT_B0     = 3'h0;
   localparam logic [2:0]  OFS_COUNT_B3     = 3'h3;
   localparam logic [2:0]  OFS_ENABLE       = 3'h4;
   localparam logic [2:0]  OFS_INDEX        = 3'h5;
   localparam logic [2:0]  OFS_COMMAND      = 3'h6;
   localparam logic [2:0]  OFS_INDEX_ALT    = 3'h7;
   localparam int          BIT_SEL_LO       = 0;
   localparam int          BIT_SEL_HI       = 1;
   localparam int          BIT_READ         = 2;
   localparam int          BIT_CLEAR_ONE    = 3;
   localparam int          BIT_CLEAR_EVERY  = 4;
   localparam int          BIT_LED          = 5;
   localparam int          BIT_PENDING      = 7;
   localparam int          BUSY_NS          = 3000;
   localparam int          BUSY_CYCLES      = (BUSY_NS * CLOCK_KHZ + 999999) / 1000000;
   localparam int          EDGE_RATE_KHZ    = 1500;
   localparam int          EDGE_GAP_CYCLES  = (CLOCK_KHZ + EDGE_RATE_KHZ - 1) / EDGE_RATE_KHZ;
   localparam int          TIMEBASE_KHZ     = 500;
   localparam int          TIMEBASE_CYCLES  = CLOCK_KHZ / TIMEBASE_KHZ;
   localparam logic [3:0]  ENABLE_RESET     = 4'h0;
   localparam logic [31:0] COUNT_RESET      = 32'h0000_0000;

   typedef struct packed {
      logic [2:0] ofs;
      logic [7:0] data;
      logic       wr;
      logic       rd;
   } host_req_s;

   typedef struct packed {
      logic [NUM_CH-1:0] phase_a;
      logic [NUM_CH-1:0] phase_b;
      logic [NUM_CH-1:0] index;
   } encoder_pins_s;

   typedef enum logic [1:0] {CMD_IDLE, CMD_RUN} cmd_state_e;
endpackage

// *** rtl/quad_counter.sv ***
// Purpose: four 32-bit quadrature counters with index-armed enables and host byte registers
// Assumes: encoder pins and jumpers asynchronous; host strobes are one-cycle, synchronous
// Notes: counts are sampled into a latch on a read command; busy spans the command time
`timescale 1ns/10ps
// Notes on behaviour
// - latched count bytes at offsets zero to three
// - latch holds until next read command
// - enable flop: software set/clear, index sets
// - primed channel starts on index at phase 00
// - software clear ignored while index active
// - index changes after enable have no effect
// - offset four: enables bits 0-3, busy bit 7
// - newly enabled decoder waits for phases 00
// - offset five: live active-high index, busy
// - timebase mode: channel three counts 500 kHz
// - timebase mode ignores enable and index three
// - edges limited to 1.5 million per second
// - command bits: select, read, clear, all, led
// - read or clear sets busy until done
// - busy on bit seven of offsets four to seven
// - polarity jumper sets index active level
module quad_counter
   import quad_count_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          srst_i,
   input  wire host_req_s     host_i,
   input  wire encoder_pins_s pins_i,
   input  wire logic          timebase_mode_jumper_i,
   input  wire logic          index_polarity_jumper_i,
   output logic [7:0]         rdata_o,
   output logic               led_o
);
   // three-stage synchronisers; stage two and three must agree
   localparam int NSYNC = 3 * NUM_CH + 2;
   logic [NSYNC-1:0] s1, s2, s3, clean;
   logic [NSYNC-1:0] next_clean;
   always_ff @(posedge clock_i) begin
      s1    <= {timebase_mode_jumper_i, index_polarity_jumper_i, pins_i.index, pins_i.phase_b, pins_i.phase_a};
      s2    <= s1;
      s3    <= s2;
      clean <= next_clean;
   end
   always_comb begin
      for (int i = 0; i < NSYNC; i++) begin
         next_clean[i] = (s2[i] == s3[i]) ? s3[i] : clean[i];
      end
   end
   logic [NUM_CH-1:0] pa, pb, idx_raw, idx_act;
   logic              pol_high, tb_mode;
   assign pa       = clean[NUM_CH-1:0];
   assign pb       = clean[2*NUM_CH-1:NUM_CH];
   assign idx_raw  = clean[3*NUM_CH-1:2*NUM_CH];
   assign pol_high = clean[3*NUM_CH];
   assign tb_mode  = clean[3*NUM_CH+1];
   assign idx_act  = pol_high ? idx_raw : ~idx_raw;

   // command sequencer
   cmd_state_e        state, next_state;
   logic [15:0]       busy_cnt, next_busy_cnt;
   logic [2:0]        cmd, next_cmd;
   logic [1:0]        sel, next_sel;
   logic              led, next_led;
   logic              busy;
   logic              do_latch, do_clear_one, do_clear_all;
   logic              cmd_wr;
   assign cmd_wr = host_i.wr && host_i.ofs == OFS_COMMAND;
   assign busy   = (state == CMD_RUN);
   always_comb begin
      next_state    = state;
      next_busy_cnt = busy_cnt;
      next_cmd      = cmd;
      next_sel      = sel;
      next_led      = led;
      do_latch      = 1'b0;
      do_clear_one  = 1'b0;
      do_clear_all  = 1'b0;
      if (cmd_wr) begin
         next_led = host_i.data[BIT_LED];
      end
      case (state)
         CMD_IDLE: begin
            if (cmd_wr && (host_i.data[BIT_READ] || host_i.data[BIT_CLEAR_ONE] || host_i.data[BIT_CLEAR_EVERY])) begin
               next_state    = CMD_RUN;
               next_busy_cnt = 16'(BUSY_CYCLES - 1);
               next_cmd      = {host_i.data[BIT_CLEAR_EVERY], host_i.data[BIT_CLEAR_ONE], host_i.data[BIT_READ]};
               next_sel      = {host_i.data[BIT_SEL_HI], host_i.data[BIT_SEL_LO]};
            end
         end
         CMD_RUN: begin
            if (busy_cnt == 16'h0000) begin
               next_state   = CMD_IDLE;
               do_latch     = cmd[0];
               do_clear_one = cmd[1];
               do_clear_all = cmd[2];
            end else begin
               next_busy_cnt = busy_cnt - 16'h0001;
            end
         end
         default: next_state = CMD_IDLE;
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state    <= CMD_IDLE;
         busy_cnt <= 16'h0000;
         cmd      <= 3'h0;
         sel      <= 2'h0;
         led      <= 1'b0;
      end else begin
         state    <= next_state;
         busy_cnt <= next_busy_cnt;
         cmd      <= next_cmd;
         sel      <= next_sel;
         led      <= next_led;
      end
   end

   // edge-rate pacing shared by all channels and 500 kHz timebase tick
   logic [7:0] gap, next_gap, tb, next_tb;
   logic       slot, tick;
   assign slot = (gap == 8'h00);
   assign tick = (tb == 8'h00);
   always_comb begin
      next_gap = slot ? 8'(EDGE_GAP_CYCLES - 1) : gap - 8'h01;
      next_tb  = tick ? 8'(TIMEBASE_CYCLES - 1) : tb - 8'h01;
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         gap <= 8'h00;
         tb  <= 8'h00;
      end else begin
         gap <= next_gap;
         tb  <= next_tb;
      end
   end

   // per-channel enable, decoder and counter
   logic [31:0]       count [NUM_CH];
   logic [31:0]       next_count [NUM_CH];
   logic [NUM_CH-1:0] enable, next_enable, armed, next_armed;
   logic [NUM_CH-1:0] last_a, last_b, next_last_a, next_last_b;
   logic              en_wr;
   assign en_wr = host_i.wr && host_i.ofs == OFS_ENABLE;
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic timebase;
      assign timebase = tb_mode && (c == NUM_CH - 1);
      always_comb begin
         next_enable[c] = enable[c];
         if (en_wr && !idx_act[c]) begin
            next_enable[c] = host_i.data[c];
         end
         if (idx_act[c]) begin
            next_enable[c] = 1'b1;
         end
         next_armed[c]  = armed[c];
         next_last_a[c] = last_a[c];
         next_last_b[c] = last_b[c];
         next_count[c]  = count[c];
         if (!enable[c]) begin
            next_armed[c] = 1'b0;
         end else if (!armed[c]) begin
            if (!pa[c] && !pb[c]) begin
               next_armed[c]  = 1'b1;
               next_last_a[c] = 1'b0;
               next_last_b[c] = 1'b0;
            end
         end else if (slot && (pa[c] != last_a[c] || pb[c] != last_b[c])) begin
            next_last_a[c] = pa[c];
            next_last_b[c] = pb[c];
            if ((pa[c] != last_a[c]) && (pb[c] != last_b[c])) begin
               next_count[c] = count[c];
            end else if ((pa[c] ^ last_b[c]) == 1'b1 && pa[c] != last_a[c]) begin
               next_count[c] = count[c] + 32'h0000_0001;
            end else if (pb[c] != last_b[c] && (pb[c] ^ last_a[c]) == 1'b0) begin
               next_count[c] = count[c] + 32'h0000_0001;
            end else begin
               next_count[c] = count[c] - 32'h0000_0001;
            end
         end
         if (timebase) begin
            next_count[c] = tick ? count[c] + 32'h0000_0001 : count[c];
         end
         if (do_clear_all || (do_clear_one && sel == 2'(c))) begin
            next_count[c] = COUNT_RESET;
         end
      end
      always_ff @(posedge clock_i) begin
         if (srst_i) begin
            enable[c] <= ENABLE_RESET[c];
            armed[c]  <= 1'b0;
            last_a[c] <= 1'b0;
            last_b[c] <= 1'b0;
            count[c]  <= COUNT_RESET;
         end else begin
            enable[c] <= next_enable[c];
            armed[c]  <= next_armed[c];
            last_a[c] <= next_last_a[c];
            last_b[c] <= next_last_b[c];
            count[c]  <= next_count[c];
         end
      end
   end

   // latch and read mux
   logic [31:0] latch, next_latch;
   logic [7:0]  next_rdata;
   always_comb begin
      next_latch = do_latch ? count[sel] : latch;
      next_rdata = 8'h00;
      if (host_i.rd) begin
         case (host_i.ofs)
            OFS_ENABLE, OFS_COMMAND:  next_rdata = {busy, 3'h0, enable};
            OFS_INDEX, OFS_INDEX_ALT: next_rdata = {busy, 3'h0, idx_act};
            default:                  next_rdata = latch[8*host_i.ofs[1:0] +: 8];
         endcase
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         latch   <= COUNT_RESET;
         rdata_o <= 8'h00;
         led_o   <= 1'b0;
      end else begin
         latch   <= next_latch;
         rdata_o <= next_rdata;
         led_o   <= next_led;
      end
   end
endmodule // quad_counter

// *** verification/quad_counter_properties.sv ***
// Purpose: port-level checks of the quadrature counter
// Assumes: one clock domain, synchronous reset
// Notes: busy time is tracked from accepted command writes
`timescale 1ns/10ps
module quad_counter_properties
   import quad_count_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          srst_i,
   input  wire host_req_s     host_i,
   input  wire encoder_pins_s pins_i,
   input  wire logic          timebase_mode_jumper_i,
   input  wire logic          index_polarity_jumper_i,
   input  wire logic [7:0]    rdata_o,
   input  wire logic          led_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   logic [8:0] bcnt;
   logic [7:0] held [4];
   logic [3:0] hv;
   logic [1:0] oq;
   logic       rq;
   logic       cwr;
   logic       go;
   logic       rs;
   assign cwr = host_i.wr && host_i.ofs == OFS_COMMAND;
   assign go  = cwr && host_i.data[4:2] != 3'h0 && (bcnt == 9'h000 || bcnt > 9'h177);
   assign rs  = host_i.rd && host_i.ofs >= OFS_ENABLE;
   always_ff @(posedge clock_i) begin
      rq <= host_i.rd && host_i.ofs <= OFS_COUNT_B3;
      oq <= host_i.ofs[1:0];
      if (srst_i || bcnt == 9'h190) bcnt <= 9'h000;
      else if (go) bcnt <= 9'h001;
      else if (bcnt != 9'h000) bcnt <= bcnt + 9'h001;
      if (srst_i || (go && host_i.data[BIT_READ]) || bcnt == 9'h178) hv <= 4'h0;
      else if (rq) begin
         hv[oq]   <= 1'b1;
         held[oq] <= rdata_o;
      end
   end
   sequence idx_calm;
      ($stable(pins_i.index) && $stable(index_polarity_jumper_i)) [*8];
   endsequence
   AST_RDATA_IDLE: assert property (!host_i.rd |=> rdata_o == 8'h00)
      else $error("read data not zero without read");
   AST_LED_SET: assert property (cwr |=> led_o == $past(host_i.data[BIT_LED]))
      else $error("led bit not taken from command");
   AST_LED_HOLD: assert property (!$past(cwr) |-> $stable(led_o))
      else $error("led changed without command");
   AST_SPARE_BITS: assert property (rs |=> rdata_o[6:4] == 3'h0)
      else $error("unused status bits set");
   AST_INDEX_LIVE: assert property (idx_calm ##0
      (host_i.rd && (host_i.ofs == OFS_INDEX || host_i.ofs == OFS_INDEX_ALT))
      |=> rdata_o[3:0] == ($past(pins_i.index) ^ {4{!index_polarity_jumper_i}}))
      else $error("index status wrong");
   AST_BUSY_ON: assert property (rs && bcnt >= 9'h002 && bcnt <= 9'h172 |=> rdata_o[7])
      else $error("busy low during command");
   AST_BUSY_OFF: assert property (rs && bcnt == 9'h000 |=> !rdata_o[7])
      else $error("busy high while idle");
   AST_LATCH_HOLD: assert property (rq && hv[oq] |-> rdata_o == held[oq])
      else $error("latched count changed");
   COV_READ: cover property (go && host_i.data[BIT_READ]);
   COV_CLEAR_ALL: cover property (go && host_i.data[BIT_CLEAR_EVERY]);
   COV_INDEX: cover property (host_i.rd && host_i.ofs == OFS_INDEX ##1 rdata_o[3:0] != 4'h0);
endmodule // quad_counter_properties
bind quad_counter quad_counter_properties chk (.clock_i, .srst_i, .host_i, .pins_i,
   .timebase_mode_jumper_i, .index_polarity_jumper_i, .rdata_o, .led_o);

// *** verification/encoder_model.sv ***
// Purpose: four quadrature encoders stepped by the bench
// Assumes: one step per pulse
// Notes: state 0 is phases 00
`timescale 1ns/10ps
module encoder_model (
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic [3:0] step_i,
   input  wire logic [3:0] dir_i,
   output logic      [3:0] phase_a_o,
   output logic      [3:0] phase_b_o
);
   logic [1:0] st [4];
   always_ff @(posedge clock_i) begin
      for (int c = 0; c < 4; c++) begin
         if (srst_i) st[c] <= 2'h0;
         else if (step_i[c]) st[c] <= dir_i[c] ? st[c] + 2'h1 : st[c] - 2'h1;
      end
   end
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         phase_a_o[c] = st[c] == 2'h1 || st[c] == 2'h2;
         phase_b_o[c] = st[c][1];
      end
   end
endmodule // encoder_model

// *** verification/quad_counter_bench.sv ***
// Purpose: self-checking bench for the quadrature counter
// Assumes: host strobes one cycle, encoders from encoder_model
// Notes: encoder steps are paced by the bench; fast steps probe the edge-rate cap
`timescale 1ns/10ps
module quad_counter_bench;
   import quad_count_pkg::*;
   logic          clock_i = 1'b0;
   logic          srst_i  = 1'b1;
   host_req_s     host_i  = '0;
   encoder_pins_s pins_i;
   logic [3:0]    pa, pb, step = 4'h0, dir = 4'h0, idx = 4'h0;
   logic          tmode = 1'b0, pol = 1'b1, led_o;
   logic [7:0]    rdata_o, b;
   logic [31:0]   v;
   int            n_mismatch = 0, tests_run = 0, cyc = 0, t0, t1;
   assign pins_i = '{pa, pb, idx};
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         test_done();
      end
   end
   encoder_model enc (.clock_i, .srst_i, .step_i(step), .dir_i(dir), .phase_a_o(pa), .phase_b_o(pb));
   quad_counter dut (.clock_i, .srst_i, .host_i, .pins_i, .timebase_mode_jumper_i(tmode),
      .index_polarity_jumper_i(pol), .rdata_o, .led_o);
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end
      else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkr(input string nm, input int e, input logic [31:0] g);
      tests_run++;
      if (^g === 1'bx || g - 32'(e - 1) > 32'h2) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0d seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input int lim, input logic [31:0] g);
      tests_run++;
      if (^g === 1'bx || g > 32'(lim)) begin
         n_mismatch++;
         $display("[FAIL] %s expected at most %0d seen %h", nm, lim, g);
      end
   endtask
   task automatic wr(input logic [2:0] o, input logic [7:0] d);
      @(posedge clock_i) host_i <= '{o, d, 1'b1, 1'b0};
      @(posedge clock_i) host_i <= '0;
   endtask
   task automatic rd(input logic [2:0] o, output logic [7:0] d);
      @(posedge clock_i) host_i <= '{o, 8'h00, 1'b0, 1'b1};
      @(posedge clock_i) host_i <= '0;
      #1 d = rdata_o;
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(OFS_COMMAND, c);
      rd(OFS_COMMAND, b);
      chk("busy set", 32'h1, 32'(b[7]));
      for (int i = 0; i < 300 && b[7] !== 1'b0; i++) rd(OFS_COMMAND, b);
      chk("busy clear", 32'h0, 32'(b[7]));
   endtask
   task automatic rdcnt(input logic [1:0] ch, output logic [31:0] r);
      cmd(8'h84 | 8'(ch));
      for (int i = 0; i < 4; i++) begin
         rd(3'(i), b);
         r[8*i +: 8] = b;
      end
   endtask
   task automatic wen(input logic [7:0] d);
      for (int i = 0; i < 4 && (i == 0 || b[3:0] !== d[3:0]); i++) begin
         wr(OFS_ENABLE, d);
         rd(OFS_ENABLE, b);
      end
   endtask
   task automatic mv(input int ch, input logic dr, input int n, input int gap = 100);
      repeat (n) begin
         @(posedge clock_i) step[ch] <= 1'b1;
         dir[ch] <= dr;
         @(posedge clock_i) step[ch] <= 1'b0;
         repeat (gap) @(posedge clock_i);
      end
   endtask
   initial begin
      repeat (20) @(posedge clock_i);
      srst_i <= 1'b0;
      rdcnt(0, v); chk("count reset", 32'h0, v);
      rd(OFS_ENABLE, b); chk("enable reset", 32'h0, 32'(b));
      $display("test reset done");
      wen(8'h01); chk("enable ch0", 32'h1, 32'(b));
      mv(0, 1'b1, 6);
      mv(0, 1'b0, 2);
      rdcnt(0, v); chk("count up down", 32'h4, v);
      cmd(8'h88);
      rd(OFS_COUNT_B0, b); chk("latch held", 32'h4, 32'(b));
      rdcnt(0, v); chk("count cleared", 32'h0, v);
      mv(0, 1'b0, 1);
      rdcnt(0, v); chk("count wrap", 32'hffff_ffff, v);
      $display("test count done");
      rd(OFS_INDEX, b); chk("index idle", 32'h0, 32'(b));
      wen(8'h01);
      cmd(8'h89);
      mv(1, 1'b1, 4);
      rdcnt(1, v); chk("primed still", 32'h0, v);
      @(posedge clock_i) idx <= 4'h2;
      repeat (20) @(posedge clock_i);
      rd(OFS_INDEX, b); chk("index live", 32'h2, 32'(b));
      wr(OFS_ENABLE, 8'h01);
      rd(OFS_ENABLE, b); chk("enable kept", 32'h3, 32'(b));
      @(posedge clock_i) idx <= 4'h0;
      mv(1, 1'b1, 3);
      rdcnt(1, v); chk("homed count", 32'h3, v);
      @(posedge clock_i) pol <= 1'b0;
      idx <= 4'hd;
      repeat (20) @(posedge clock_i);
      rd(OFS_INDEX_ALT, b); chk("index low active", 32'h2, 32'(b));
      @(posedge clock_i) pol <= 1'b1;
      idx <= 4'h0;
      $display("test index done");
      cmd(8'hb0);
      chk("led on", 32'h1, 32'(led_o));
      for (int c = 0; c < 2; c++) begin
         rdcnt(2'(c), v); chk("clear all", 32'h0, v);
      end
      mv(0, 1'b1, 40, 40);
      rdcnt(0, v); chkb("rate limit", 40 * 42 / EDGE_GAP_CYCLES + 2, v);
      $display("test rate done");
      wr(OFS_COMMAND, 8'h00);
      #1 chk("led off", 32'h0, 32'(led_o));
      @(posedge clock_i) tmode <= 1'b1;
      repeat (20) @(posedge clock_i);
      t0 = cyc;
      cmd(8'h8b);
      mv(3, 1'b0, 3);
      @(posedge clock_i) idx <= 4'h8;
      repeat (2200) @(posedge clock_i);
      t1 = cyc;
      rdcnt(3, v); chkr("timebase", (t1 - t0) / TIMEBASE_CYCLES, v);
      $display("test timebase done");
      test_done();
   end
endmodule // quad_counter_bench
